//--- pkg/pdmc_pkg.sv
package pdmc_pkg;

  // register port
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_MSTBY = 3'h1;
  localparam logic [2:0] REG_MODE = 3'h2;
  localparam logic [2:0] REG_STAT = 3'h3;
  localparam logic [2:0] REG_CLR = 3'h4;
  localparam logic [2:0] REG_EN = 3'h5;

  // control register fields
  localparam int CB_DIV = 0;
  localparam int CB_LOW_SPEED_ON_BIT = 3;
  localparam int CB_MEDIUM_SPEED_ON_BIT = 4;
  localparam int CB_DIRECT_TRANSFER_BIT = 5;
  localparam int CB_TMS = 6;
  localparam int CB_SOFTWARE_STANDBY_BIT = 7;
  localparam int CTRL_W = 8;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // peripheral slots
  localparam int NPER = 12;
  localparam int P_TMR_A = 0;
  localparam int P_TMR_C = 1;
  localparam int P_TMR_F = 2;
  localparam int P_TMR_G = 3;
  localparam int P_WDT = 4;
  localparam int P_SER1 = 5;
  localparam int P_SER2 = 6;
  localparam int P_SER3 = 7;
  localparam int P_AEC = 8;
  localparam int P_LCD = 9;
  localparam int P_PWM = 10;
  localparam int P_ADC = 11;
  localparam logic [11:0] SUBSLP_MASK = 12'h3ff;
  localparam logic [11:0] WATCH_MASK = 12'h30d;
  localparam logic [11:0] MSTBY_RST = 12'h000;

  // pin synchroniser slots
  localparam int N_EXT = 5;
  localparam int N_WKP = 8;
  localparam int NSYNC = 14;
  localparam int S_SUBCLK = 13;

  // interrupt events
  localparam int NEV = 3;
  localparam int EV_SLEEP = 0;
  localparam int EV_WAKE = 1;
  localparam int EV_REFUSE = 2;

  // peripheral divider: 1/64, 1/32, 1/16, 1/8
  localparam int DIV_W = 6;
  localparam logic [5:0] DIV_TOP = 6'h3f;

  typedef enum logic [7:0] {
    M_ACT_HS = 8'h01,
    M_ACT_MS = 8'h02,
    M_SUB_ACT = 8'h04,
    M_SLP_HS = 8'h08,
    M_SLP_MS = 8'h10,
    M_SUB_SLP = 8'h20,
    M_WATCH = 8'h40,
    M_STBY = 8'h80
  } pdmc_mode_t;

endpackage

//--- design/pdmc_tick.sv
`timescale 1ns/100ps
module pdmc_tick
  import pdmc_pkg::*;
#(
  parameter int W = DIV_W
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // control
  input wire logic run,
  input wire logic [1:0] sel,
  // tick out
  output logic tick
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } pdmc_tick_st_t;

  pdmc_tick_st_t s;
  pdmc_tick_st_t next_s;
  logic [W-1:0] top;

  generate
    if (W < DIV_W) begin : g_chk
      $error("pdmc_tick: counter too narrow for 1/64");
    end
  endgenerate

  assign top = W'(DIV_TOP >> sel);

  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run) begin
      next_s.cnt = '0;
    end else if (s.cnt >= top) begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.cnt = s.cnt + W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule

//--- design/pdmc_core.sv
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module pdmc_core
  import pdmc_pkg::*;
#(
  parameter int NP = NPER
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  output logic irq,
  // cpu side
  input wire logic sleep_req,
  input wire logic irq_pending,
  input wire logic irq_ack,
  output logic cpu_wake_req,
  output logic cpu_run,
  output logic cpu_clk_sub,
  output logic cpu_clk_en,
  // internal interrupt sources
  input wire logic tmr_a_irq,
  input wire logic tmr_c_irq,
  input wire logic tmr_f_irq,
  input wire logic tmr_g_irq,
  input wire logic serial_unit_one_irq,
  input wire logic serial_unit_two_irq,
  input wire logic serial_unit_three_irq,
  input wire logic async_event_counter_irq,
  input wire logic other_irq,
  // pins
  input wire logic [N_EXT-1:0] ext_irq_n,
  input wire logic [N_WKP-1:0] wakeup_pin_n,
  input wire logic sub_clk,
  // clock control
  output logic sys_osc_en,
  output logic [NP-1:0] periph_clk_en
);

  generate
    if (NP != NPER) begin : g_chk
      $error("pdmc_core: peripheral count is fixed");
    end
  endgenerate

  typedef struct packed {
    pdmc_mode_t mode;
    logic [NSYNC-1:0] s1, s2, s3, stab;
    logic wake_pend;
    logic [CTRL_W-1:0] ctrl;
    logic [NP-1:0] mstby;
    logic [NEV-1:0] stat;
    logic [NEV-1:0] en;
    logic [DATA_W-1:0] rdata;
    logic irq;
    logic cpu_run;
    logic cpu_sub;
    logic cpu_clk_en;
    logic sys_osc;
    logic [NP-1:0] periph;
  } pdmc_st_t;

  pdmc_st_t s, next_s;
  logic div_tick, sub_tick, wake_src, sleeping, running;
  logic grp1, grp2, grp3, grp4;
  logic [NSYNC-1:0] pins, next_stab;
  logic [N_EXT-1:0] ext_evt;
  logic [N_WKP-1:0] wkp_evt;
  logic [NP-1:0] gate;
  logic [NEV-1:0] ev;
  pdmc_mode_t act_tgt, sleep_tgt, wake_tgt;

  wire low_speed_on_bit = s.ctrl[CB_LOW_SPEED_ON_BIT];
  wire medium_speed_on_bit = s.ctrl[CB_MEDIUM_SPEED_ON_BIT];
  wire direct_transfer_bit = s.ctrl[CB_DIRECT_TRANSFER_BIT];
  wire tms = s.ctrl[CB_TMS];
  wire software_standby_bit = s.ctrl[CB_SOFTWARE_STANDBY_BIT];
  wire [1:0] div_sel = s.ctrl[CB_DIV +: 2];

  // prescaler runs only while the system oscillator runs
  pdmc_tick #(
    .W(DIV_W)
  ) u_tick (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .run(s.sys_osc),
    .sel(div_sel),
    .tick(div_tick)
  );
  assign pins = {sub_clk, wakeup_pin_n, ext_irq_n};
  // pin filter: accept a level once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_pin
      assign next_stab[gi] = (s.s2[gi] == s.s3[gi]) ? s.s3[gi] : s.stab[gi];
    end
  endgenerate

  // falling edges on the interrupt and wakeup pins, rising edge on the subclock, seen in every mode
  assign ext_evt = s.stab[N_EXT-1:0] & ~next_stab[N_EXT-1:0];
  assign wkp_evt = s.stab[N_EXT +: N_WKP] & ~next_stab[N_EXT +: N_WKP];
  assign sub_tick = next_stab[S_SUBCLK] & ~s.stab[S_SUBCLK];
  // timers A F G, ext0, wakeup
  assign grp1 = tmr_a_irq | tmr_f_irq | tmr_g_irq | ext_evt[0] | (|wkp_evt);
  assign grp2 = tmr_a_irq | tmr_c_irq | tmr_f_irq | tmr_g_irq
              | serial_unit_one_irq | serial_unit_two_irq
              | serial_unit_three_irq | (|ext_evt) | (|wkp_evt)
              | async_event_counter_irq;
  assign grp3 = grp2 | other_irq;
  assign grp4 = ext_evt[1] | ext_evt[0] | (|wkp_evt);

  assign sleeping = (s.mode == M_SLP_HS) || (s.mode == M_SLP_MS)
                 || (s.mode == M_SUB_SLP) || (s.mode == M_WATCH)
                 || (s.mode == M_STBY);
  assign running = (s.mode == M_ACT_HS) || (s.mode == M_ACT_MS)
                || (s.mode == M_SUB_ACT);

  always_comb begin
    unique case (s.mode)
      M_SLP_HS, M_SLP_MS: wake_src = grp3;
      M_SUB_SLP: wake_src = grp2;
      M_WATCH: wake_src = grp1;
      M_STBY: wake_src = grp4;
      default: wake_src = 1'b0;
    endcase
  end

  always_comb begin
    act_tgt = medium_speed_on_bit ? M_ACT_MS : M_ACT_HS;
    sleep_tgt = s.mode;
    wake_tgt = act_tgt;
    if (s.mode == M_SUB_ACT) begin
      if (direct_transfer_bit && !low_speed_on_bit) begin
        sleep_tgt = act_tgt;
      end else if (software_standby_bit) begin
        sleep_tgt = M_WATCH;
      end else begin
        sleep_tgt = M_SUB_SLP;
      end
    end else if (direct_transfer_bit) begin
      sleep_tgt = (low_speed_on_bit && tms) ? M_SUB_ACT : act_tgt;
    end else if (software_standby_bit) begin
      sleep_tgt = tms ? M_WATCH : M_STBY;
    end else if (low_speed_on_bit && tms) begin
      sleep_tgt = M_SUB_SLP;
    end else begin
      sleep_tgt = medium_speed_on_bit ? M_SLP_MS : M_SLP_HS;
    end
    if (((s.mode == M_SUB_SLP) || (s.mode == M_WATCH)) && low_speed_on_bit) begin
      wake_tgt = M_SUB_ACT;
    end
  end

  // per-peripheral clock gating
  generate
    for (gi = 0; gi < NP; gi++) begin : g_per
      always_comb begin
        unique case (s.mode)
          M_ACT_HS, M_SLP_HS: gate[gi] = 1'b1;
          M_ACT_MS, M_SLP_MS: gate[gi] = div_tick;
          M_SUB_SLP, M_SUB_ACT: gate[gi] = SUBSLP_MASK[gi] & sub_tick;
          M_WATCH: gate[gi] = WATCH_MASK[gi] & sub_tick;
          default: gate[gi] = 1'b0;
        endcase
      end
    end
  endgenerate

  always_comb begin
    next_s = s;
    ev = '0;
    next_s.s1 = pins;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    next_s.stab = next_stab;
    // mode register steps between eight modes
    if (sleeping) begin
      if (s.wake_pend && irq_ack) begin
        next_s.mode = wake_tgt;
        next_s.wake_pend = 1'b0;
        ev[EV_WAKE] = 1'b1;
      end else if (wake_src) begin
        next_s.wake_pend = 1'b1;
      end
    end else if (running && sleep_req) begin
      // no transition while a request is pending
      if (irq_pending) begin
        ev[EV_REFUSE] = 1'b1;
      end else begin
        next_s.mode = sleep_tgt;
        ev[EV_SLEEP] = 1'b1;
      end
    end
    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL: next_s.ctrl = reg_wdata[CTRL_W-1:0];
        REG_MSTBY: next_s.mstby = reg_wdata[NP-1:0];
        REG_EN: next_s.en = reg_wdata[NEV-1:0];
        REG_CLR: next_s.stat = s.stat & ~reg_wdata[NEV-1:0];
        default: ;
      endcase
    end
    // set wins over clear
    next_s.stat = next_s.stat | ev;
    next_s.irq = |(next_s.stat & next_s.en);
    next_s.rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL: next_s.rdata = DATA_W'(s.ctrl);
        REG_MSTBY: next_s.rdata = DATA_W'(s.mstby);
        REG_MODE: next_s.rdata = DATA_W'(s.mode);
        REG_STAT: next_s.rdata = DATA_W'(s.stat);
        REG_EN: next_s.rdata = DATA_W'(s.en);
        default: next_s.rdata = '0;
      endcase
    end
    // system oscillator stops in subclock modes
    next_s.sys_osc = !((next_s.mode == M_SUB_ACT)
                    || (next_s.mode == M_SUB_SLP)
                    || (next_s.mode == M_WATCH)
                    || (next_s.mode == M_STBY));
    next_s.cpu_run = (next_s.mode == M_ACT_HS) || (next_s.mode == M_ACT_MS)
                  || (next_s.mode == M_SUB_ACT);
    next_s.cpu_sub = (next_s.mode == M_SUB_ACT);
    // CPU clock rate per active mode
    unique case (s.mode)
      M_ACT_HS: next_s.cpu_clk_en = 1'b1;
      M_ACT_MS: next_s.cpu_clk_en = div_tick;
      M_SUB_ACT: next_s.cpu_clk_en = sub_tick;
      default: next_s.cpu_clk_en = 1'b0;
    endcase
    next_s.periph = gate & ~s.mstby;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s <= '0;
      s.mode <= M_ACT_HS;
      s.s1 <= '1;
      s.s2 <= '1;
      s.s3 <= '1;
      s.stab <= '1;
      s.ctrl <= CTRL_RST;
      s.mstby <= MSTBY_RST;
      s.sys_osc <= 1'b1;
      s.cpu_run <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign reg_rdata = s.rdata;
  assign irq = s.irq;
  assign cpu_wake_req = s.wake_pend;
  assign cpu_run = s.cpu_run;
  assign cpu_clk_sub = s.cpu_sub;
  assign cpu_clk_en = s.cpu_clk_en;
  assign sys_osc_en = s.sys_osc;
  assign periph_clk_en = s.periph;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  property p_act_software_standby_bit;
    (sleep_req && !irq_pending && software_standby_bit && !direct_transfer_bit && tms
     && (s.mode == M_ACT_HS || s.mode == M_ACT_MS))
    |=> (s.mode == M_WATCH) ##1 !sys_osc_en;
  endproperty
  a_act_software_standby_bit: assert property (p_act_software_standby_bit)
    else $error("active sleep with standby bit did not reach watch");
  property p_sub_software_standby_bit;
    (sleep_req && !irq_pending && software_standby_bit && (s.mode == M_SUB_ACT)
     && !(direct_transfer_bit && !low_speed_on_bit))
    |=> (s.mode == M_WATCH);
  endproperty
  a_sub_software_standby_bit: assert property (p_sub_software_standby_bit)
    else $error("subactive sleep with standby bit did not reach watch");
  property p_hold;
    (sleeping && !irq_ack) |=> (s.mode == $past(s.mode));
  endproperty
  a_hold: assert property (p_hold)
    else $error("mode left sleep without interrupt acceptance");
  property p_refuse;
    (running && sleep_req && irq_pending)
    |=> $stable(s.mode) && s.stat[EV_REFUSE];
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("sleep taken while an interrupt was pending");
  property p_stby;
    (s.mode == M_STBY) [*2] |-> (periph_clk_en == '0) && !cpu_clk_en
                               && !cpu_run && !sys_osc_en;
  endproperty
  a_stby: assert property (p_stby)
    else $error("clock active in standby");
  property p_mstby;
    (s.mstby != '0) |=> ((periph_clk_en & $past(s.mstby)) == '0);
  endproperty
  a_mstby: assert property (p_mstby)
    else $error("peripheral in module standby still clocked");
  property p_watch_wake;
    ((s.mode == M_WATCH) && (|wkp_evt) && !irq_ack) |=> s.wake_pend;
  endproperty
  a_watch_wake: assert property (p_watch_wake)
    else $error("wakeup pin failed to wake watch mode");
  property p_stby_narrow;
    ((s.mode == M_STBY) && !grp4 && !irq_ack)
    |=> (s.wake_pend == $past(s.wake_pend));
  endproperty
  a_stby_narrow: assert property (p_stby_narrow)
    else $error("standby woken by a source outside its group");
  property p_subslp_wake;
    ((s.mode == M_SUB_SLP) && serial_unit_one_irq && !irq_ack) |=> s.wake_pend;
  endproperty
  a_subslp_wake: assert property (p_subslp_wake)
    else $error("serial interrupt failed to wake subsleep");
  property p_watch_set;
    (s.mode == M_WATCH) [*2] |-> ((periph_clk_en & ~WATCH_MASK) == '0);
  endproperty
  a_watch_set: assert property (p_watch_set)
    else $error("peripheral outside watch set clocked");
  property p_div8;
    ((s.mode == M_SLP_MS) && (div_sel == 2'h3) && periph_clk_en[P_TMR_A])
    |=> !periph_clk_en[P_TMR_A] [*7];
  endproperty
  a_div8: assert property (p_div8)
    else $error("sleep medium-speed tick spacing wrong");

endmodule

//--- tb/pdmc_cpu_model.sv
`timescale 1ns/100ps
module pdmc_cpu_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // bench control
  input wire logic do_sleep,
  input wire logic hold_pend,
  input wire logic [3:0] ack_dly,
  // controller side
  input wire logic cpu_run,
  input wire logic cpu_wake_req,
  output logic sleep_req,
  output logic irq_pending,
  output logic irq_ack
);
  logic [3:0] cnt;

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sleep_req <= 1'b0;
      irq_pending <= 1'b0;
      irq_ack <= 1'b0;
      cnt <= 4'h0;
    end else begin
      sleep_req <= do_sleep & cpu_run;
      irq_pending <= hold_pend;
      irq_ack <= 1'b0;
      cnt <= 4'h0;
      if (cpu_wake_req && !irq_ack) begin
        if (cnt == ack_dly) begin
          irq_ack <= 1'b1;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/100ps
module tb_top
  import pdmc_pkg::*;
;
  logic ref_clk, rstn, reg_wr, reg_rd, irq, sub_clk;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic sleep_req, irq_pending, irq_ack, cpu_wake_req, cpu_run;
  logic cpu_clk_sub, cpu_clk_en, sys_osc_en, do_sleep, hold_pend;
  logic [3:0] ack_dly;
  logic [8:0] src;
  logic [4:0] ext_irq_n;
  logic [7:0] wakeup_pin_n;
  logic [11:0] periph_clk_en, seen;
  int n_mismatch, samples_checked, n_tick, n_cpu;

  pdmc_core u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .sleep_req(sleep_req),
    .irq_pending(irq_pending), .irq_ack(irq_ack),
    .cpu_wake_req(cpu_wake_req), .cpu_run(cpu_run),
    .cpu_clk_sub(cpu_clk_sub), .cpu_clk_en(cpu_clk_en),
    .tmr_a_irq(src[0]), .tmr_c_irq(src[1]), .tmr_f_irq(src[2]),
    .tmr_g_irq(src[3]), .serial_unit_one_irq(src[4]),
    .serial_unit_two_irq(src[5]), .serial_unit_three_irq(src[6]),
    .async_event_counter_irq(src[7]), .other_irq(src[8]),
    .ext_irq_n(ext_irq_n), .wakeup_pin_n(wakeup_pin_n),
    .sub_clk(sub_clk), .sys_osc_en(sys_osc_en),
    .periph_clk_en(periph_clk_en)
  );

  pdmc_cpu_model u_cpu (
    .ref_clk(ref_clk), .rstn(rstn), .do_sleep(do_sleep),
    .hold_pend(hold_pend), .ack_dly(ack_dly), .cpu_run(cpu_run),
    .cpu_wake_req(cpu_wake_req), .sleep_req(sleep_req),
    .irq_pending(irq_pending), .irq_ack(irq_ack)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // subclock pin, unrelated in phase
  initial begin
    sub_clk = 1'b0;
    forever #417 sub_clk = ~sub_clk;
  end

  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
    end
  endtask

  task wr(input logic [2:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [2:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    @(posedge ref_clk);
  endtask

  task mode_is(input pdmc_mode_t m);
    rd(REG_MODE);
    chk("mode", d, 16'(m));
  endtask

  task slp;
    @(posedge ref_clk);
    do_sleep <= 1'b1;
    @(posedge ref_clk);
    do_sleep <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task obs(input int n);
    seen = '0;
    n_tick = 0;
    n_cpu = 0;
    repeat (n) begin
      @(posedge ref_clk);
      #1;
      seen |= periph_clk_en;
      n_tick += int'(periph_clk_en[P_TMR_A]);
      n_cpu += int'(cpu_clk_en);
    end
  endtask

  task pulse(input int b);
    @(posedge ref_clk);
    src[b] <= 1'b1;
    @(posedge ref_clk);
    src[b] <= 1'b0;
  endtask

  task nowake;
    repeat (12) @(posedge ref_clk);
    #1 chk("wake", 16'(cpu_wake_req), 16'h0);
    @(posedge ref_clk);
  endtask

  task woke;
    for (int i = 0; i < 300 && cpu_run !== 1'b1; i++) begin
      @(posedge ref_clk);
      #1;
    end
    chk("run", 16'(cpu_run), 16'h1);
    @(posedge ref_clk);
  endtask

  initial begin
    #2000000;
    n_mismatch++;
    final_report;
  end

  initial begin
    rstn = 1'b0;
    {reg_wr, reg_rd, do_sleep, hold_pend} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    src = '0;
    ext_irq_n = '1;
    wakeup_pin_n = '1;
    ack_dly = 4'h2;
    repeat (3) @(posedge ref_clk);
    rstn <= 1'b1;
    mode_is(M_ACT_HS);
    rd(REG_CTRL);
    chk("ctrl", d, 16'(CTRL_RST));
    obs(8);
    chk("pclk", 16'(seen), 16'h0fff);
    chk("cpuclk", 16'(n_cpu), 16'h0008);
    chk("osc", 16'(sys_osc_en), 16'h1);
    chk("sub", 16'(cpu_clk_sub), 16'h0);
    rd(3'h6);
    chk("unmap", d, 16'h0);
    $display("reset test done");
    wr(REG_EN, 16'h0007);
    ack_dly <= 4'hf;
    slp;
    mode_is(M_SLP_HS);
    chk("run", 16'(cpu_run), 16'h0);
    obs(8);
    chk("pclk", 16'(seen), 16'h0fff);
    chk("irq", 16'(irq), 16'h1);
    pulse(0);
    repeat (6) @(posedge ref_clk);
    #1 chk("wreq", 16'(cpu_wake_req), 16'h1);
    mode_is(M_SLP_HS);
    woke;
    ack_dly <= 4'h2;
    mode_is(M_ACT_HS);
    rd(REG_STAT);
    chk("stat", d, 16'h0003);
    wr(REG_CLR, 16'h0007);
    @(posedge ref_clk);
    #1 chk("irq", 16'(irq), 16'h0);
    @(posedge ref_clk);
    hold_pend <= 1'b1;
    slp;
    mode_is(M_ACT_HS);
    rd(REG_STAT);
    chk("stat", d, 16'h0004);
    hold_pend <= 1'b0;
    wr(REG_CLR, 16'h0007);
    $display("sleep test done");
    for (int k = 0; k < 4; k++) begin
      wr(REG_CTRL, 16'h0010 | 16'(k));
      slp;
      mode_is(M_SLP_MS);
      obs(8);
      obs(128);
      chk("div", 16'(n_tick), 16'(2 << k));
      pulse(3);
      woke;
      mode_is(M_ACT_MS);
    end
    obs(128);
    chk("cpums", 16'(n_cpu), 16'h0010);
    wr(REG_CTRL, 16'h0020);
    slp;
    mode_is(M_ACT_HS);
    $display("medium test done");
    wr(REG_CTRL, 16'h0080);
    slp;
    mode_is(M_STBY);
    obs(64);
    chk("pclk", 16'(seen), 16'h0);
    chk("osc", 16'(sys_osc_en), 16'h0);
    pulse(0);
    nowake;
    ext_irq_n[2] <= 1'b0;
    nowake;
    ext_irq_n[2] <= 1'b1;
    ext_irq_n[0] <= 1'b0;
    woke;
    ext_irq_n[0] <= 1'b1;
    mode_is(M_ACT_HS);
    $display("standby test done");
    wr(REG_CTRL, 16'h00c0);
    slp;
    mode_is(M_WATCH);
    obs(200);
    chk("wpclk", 16'(seen & ~WATCH_MASK), 16'h0);
    chk("aec", 16'(seen[P_AEC]), 16'h1);
    pulse(1);
    nowake;
    pulse(2);
    woke;
    mode_is(M_ACT_HS);
    $display("watch test done");
    wr(REG_CTRL, 16'h0048);
    slp;
    mode_is(M_SUB_SLP);
    obs(200);
    chk("spclk", 16'(seen & ~SUBSLP_MASK), 16'h0);
    chk("osc", 16'(sys_osc_en), 16'h0);
    pulse(8);
    nowake;
    pulse(4);
    woke;
    mode_is(M_SUB_ACT);
    chk("sub", 16'(cpu_clk_sub), 16'h1);
    obs(200);
    chk("cpusub", 16'(n_cpu >= 5 && n_cpu <= 6), 16'h1);
    wr(REG_CTRL, 16'h0088);
    slp;
    mode_is(M_WATCH);
    wakeup_pin_n[7] <= 1'b0;
    woke;
    wakeup_pin_n[7] <= 1'b1;
    mode_is(M_SUB_ACT);
    wr(REG_CTRL, 16'h0020);
    slp;
    mode_is(M_ACT_HS);
    wr(REG_CTRL, 16'h0068);
    slp;
    mode_is(M_SUB_ACT);
    wr(REG_CTRL, 16'h0020);
    slp;
    mode_is(M_ACT_HS);
    $display("subclock test done");
    wr(REG_MSTBY, 16'h0004);
    obs(16);
    chk("mstby", 16'(seen), 16'h0ffb);
    rd(REG_MSTBY);
    chk("mstbyr", d, 16'h0004);
    $display("module standby test done");
    final_report;
  end
endmodule
